//--- core/edge_sensor_params.svh
// Purpose: Constants for the edge sensor status and position formatter
// Assumes: 16-bit status word and 16-bit position words
// Notes:   Definitions only
`ifndef EDGE_SENSOR_PARAMS_SVH
`define EDGE_SENSOR_PARAMS_SVH

// ==========================================================
// Status word field positions
`define ST_NO_SENSOR     0
`define ST_LOW_CONTRAST  1
`define ST_NO_WEB        2
`define ST_WRONG_ORIENT  3
`define ST_RSVD_A        4
`define ST_FLUTTER       5
`define ST_RSVD_B        6
`define ST_TYPE          7
`define ST_LEFT          8
`define ST_RIGHT         9
`define ST_PIX_LSB       10
`define ST_PIX_MSB       13
`define ST_MODE_LSB      14
`define ST_MODE_MSB      15

// ==========================================================
// Reset values
`define STATUS_RST       16'h0000
`define POS_RST          16'h0000

// ==========================================================
// Pixel counts, first sensor type
`define PIX_A0           16'h0100
`define PIX_A1           16'h0300
`define PIX_A2           16'h06EE
`define PIX_A3           16'h0380
`define PIX_A5           16'h0700
`define PIX_A6           16'h06EC
`define PIX_A7           16'h0DD8
`define PIX_A8           16'h0DCA

// ==========================================================
// Pixel counts, second sensor type
`define PIX_B1           16'h02F8
`define PIX_B2           16'h02FC
`define PIX_B3           16'h0600
`define PIX_B4           16'h05F6
`define PIX_B5           16'h0BEC
`define PIX_B8           16'h0BE2
`define PIX_B12          16'h17BA
`define PIX_NONE         16'h0000

`endif

//--- core/edge_sensor_pkg.sv
// Purpose: Types for the edge sensor status and position formatter
// Assumes: Constants live in edge_sensor_params.svh
// Notes:   Types only
package edge_sensor_pkg;

  // Sensing mode field encoding
  typedef enum logic [1:0]
  {
    MODE_EDGE     = 2'b00,
    MODE_CONTRAST = 2'b10
  } sense_mode_t;

  typedef logic [15:0] word_t;

endpackage

//--- core/edge_sensor_status_position_out.sv
// Purpose: Build sensor fault/status word and edge/contrast position words
// Assumes: All inputs synchronous to clk_i; meas_valid_i marks a new measurement
// Notes:   Outputs refresh one cycle after meas_valid_i; the words hold otherwise and update_o drops
//
// What this block does
// - Bit 3 flags edge seen in wrong orientation
// - Bits 4 and 6 are reserved
// - Bit 5 flags flutter or out-of-plane movement
// - Bit 7 gives sensor type, selects pixel table
// - Bit 8 set for left placement
// - Bit 9 set for right placement
// - Both placement bits mean centre sensor
// - Bits 10-13 pixel code, first type table
// - Second type pixel code table
// - Bits 14-15 mode: 0 edge, 2 contrast
// - Edge mode puts left edge in left word
// - Left word zero under right orientation
// - Right word carries right edge or contrast
// - No contrast gives total pixel count
// - Positions grow from left to right
// - Open/covered window gives pixel count or zero
// - Low byte faults plus sensor type in bit 7, high byte status
// - Bits 0-2: no sensor, low contrast, no web
`timescale 1ns/1ps
`include "edge_sensor_params.svh"

module edge_sensor_status_position_out
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Measurement strobe
  input  wire logic        meas_valid_i,
  // Fault and event flags
  input  wire logic        no_sensor_i,
  input  wire logic        low_contrast_i,
  input  wire logic        no_web_i,
  input  wire logic        wrong_orient_i,
  input  wire logic        flutter_i,
  // Sensor configuration
  input  wire logic        type_second_i,
  input  wire logic        place_left_i,
  input  wire logic        place_right_i,
  input  wire logic [3:0]  pix_code_i,
  input  wire logic        mode_contrast_i,
  // Raw measurement, pixel index counted from the left
  input  wire logic [15:0] left_edge_raw_i,
  input  wire logic [15:0] right_edge_raw_i,
  input  wire logic [15:0] contrast_pos_i,
  input  wire logic        contrast_seen_i,
  input  wire logic        win_open_i,
  input  wire logic        win_covered_i,
  // Published words
  output logic      [15:0] status_word_o,
  output logic      [15:0] left_edge_o,
  output logic      [15:0] right_pos_o,
  output logic             update_o
);

  // ========================================================
  // Pixel count lookup
  function automatic logic [15:0] pix_count(input logic typ, input logic [3:0] code);
    logic [15:0] v;
    v = `PIX_NONE;
    if (!typ)
    begin
      case (code)
        4'h0:    v = `PIX_A0;
        4'h1:    v = `PIX_A1;
        4'h2:    v = `PIX_A2;
        4'h3:    v = `PIX_A3;
        4'h5:    v = `PIX_A5;
        4'h6:    v = `PIX_A6;
        4'h7:    v = `PIX_A7;
        4'h8:    v = `PIX_A8;
        default: v = `PIX_NONE;
      endcase
    end
    else
    begin
      case (code)
        4'h1:    v = `PIX_B1;
        4'h2:    v = `PIX_B2;
        4'h3:    v = `PIX_B3;
        4'h4:    v = `PIX_B4;
        4'h5:    v = `PIX_B5;
        4'h8:    v = `PIX_B8;
        4'hC:    v = `PIX_B12;
        default: v = `PIX_NONE;
      endcase
    end
    return v;
  endfunction

  // ========================================================
  // Decode
  edge_sensor_pkg::sense_mode_t mode_w;
  logic [15:0] pix_w;
  logic        right_only_w;
  logic        left_only_w;
  logic        centre_w;
  logic        edge_mode_w;

  assign mode_w       = mode_contrast_i ? edge_sensor_pkg::MODE_CONTRAST
                                        : edge_sensor_pkg::MODE_EDGE;
  assign pix_w        = pix_count(type_second_i, pix_code_i);
  assign right_only_w = place_right_i && !place_left_i;
  assign left_only_w  = place_left_i && !place_right_i;
  assign centre_w     = place_left_i && place_right_i;
  assign edge_mode_w  = (mode_w == edge_sensor_pkg::MODE_EDGE);

  // ========================================================
  // Status word: faults in bits 0-6, sensor type in bit 7, status in the high byte
  logic [15:0] status_next;

  assign status_next = {mode_w,
                        pix_code_i,
                        place_right_i,
                        place_left_i,
                        type_second_i,
                        1'b0,
                        flutter_i,
                        1'b0,
                        wrong_orient_i,
                        no_web_i,
                        low_contrast_i,
                        no_sensor_i};

  // ========================================================
  // Position words; raw indices already rise left to right
  logic [15:0] left_edge_next;
  logic [15:0] right_edge_w;
  logic [15:0] right_pos_next;

  // Contrast mode has no meaning for the left word, so it is parked at zero
  assign left_edge_next =
      (!edge_mode_w || right_only_w)     ? `POS_RST :
      (left_only_w && win_open_i)        ? pix_w :
      (left_only_w && win_covered_i)     ? `POS_RST :
                                           left_edge_raw_i;

  assign right_edge_w =
      (right_only_w && win_open_i)       ? `POS_RST :
      (right_only_w && win_covered_i)    ? pix_w :
                                           right_edge_raw_i;

  assign right_pos_next =
      edge_mode_w      ? right_edge_w :
      contrast_seen_i  ? contrast_pos_i :
                         pix_w;

  // ========================================================
  // Output registers; words change only on a new measurement
  logic [15:0] status_reg;
  logic [15:0] left_edge_reg;
  logic [15:0] right_pos_reg;
  logic        update_reg;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      status_reg    <= `STATUS_RST;
      left_edge_reg <= `POS_RST;
      right_pos_reg <= `POS_RST;
      update_reg    <= 1'b0;
    end
    else
    begin
      update_reg <= meas_valid_i;
      if (meas_valid_i)
      begin
        status_reg    <= status_next;
        left_edge_reg <= left_edge_next;
        right_pos_reg <= right_pos_next;
      end
    end
  end

  assign status_word_o = status_reg;
  assign left_edge_o   = left_edge_reg;
  assign right_pos_o   = right_pos_reg;
  assign update_o      = update_reg;

  // ========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  wrong_orient_a: assert property
    (meas_valid_i |=> status_word_o[`ST_WRONG_ORIENT] == $past(wrong_orient_i))
    else $error("Wrong orientation bit does not follow input");

  reserved_zero_a: assert property
    (!status_word_o[`ST_RSVD_A] && !status_word_o[`ST_RSVD_B])
    else $error("Reserved status bit set");

  flutter_bit_a: assert property
    (meas_valid_i |=> status_word_o[`ST_FLUTTER] == $past(flutter_i))
    else $error("Flutter bit does not follow input");

  placement_bits_a: assert property
    (meas_valid_i |=> status_word_o[`ST_LEFT] == $past(place_left_i)
                   && status_word_o[`ST_RIGHT] == $past(place_right_i))
    else $error("Placement bits do not follow configuration");

  mode_field_a: assert property
    (meas_valid_i |=> status_word_o[`ST_MODE_MSB:`ST_MODE_LSB]
                      == ($past(mode_contrast_i) ? 2'b10 : 2'b00))
    else $error("Sensing mode field wrong");

  fault_bits_a: assert property
    (meas_valid_i |=> status_word_o[2:0]
                      == {$past(no_web_i), $past(low_contrast_i), $past(no_sensor_i)})
    else $error("Fault bits do not follow inputs");

  left_zero_a: assert property
    (update_o && status_word_o[`ST_RIGHT] && !status_word_o[`ST_LEFT]
     |-> left_edge_o == 16'h0000)
    else $error("Left word not zero under right orientation");

  no_contrast_a: assert property
    (update_o && status_word_o[`ST_MODE_MSB] && !$past(contrast_seen_i)
     |-> right_pos_o == pix_count(status_word_o[`ST_TYPE],
                                  status_word_o[`ST_PIX_MSB:`ST_PIX_LSB]))
    else $error("No-contrast position is not the pixel count");

  left_edge_pass_a: assert property
    (meas_valid_i && edge_mode_w && centre_w |=> left_edge_o == $past(left_edge_raw_i))
    else $error("Left edge not passed through");

  open_right_a: assert property
    (meas_valid_i && edge_mode_w && right_only_w && win_open_i
     |=> right_pos_o == 16'h0000)
    else $error("Open window under right orientation not zero");

  hold_words_a: assert property
    (!meas_valid_i |=> $stable(status_word_o) && $stable(right_pos_o)
                       && $stable(left_edge_o) && !update_o)
    else $error("Words changed without a measurement");

  centre_cov: cover property
    (meas_valid_i && centre_w ##1 update_o);

  contrast_cov: cover property
    (meas_valid_i && !edge_mode_w && contrast_seen_i ##1 update_o);

  covered_left_cov: cover property
    (meas_valid_i && edge_mode_w && left_only_w && win_covered_i);

  second_type_cov: cover property
    (meas_valid_i && type_second_i && pix_code_i == 4'hC ##1 update_o);

endmodule

//--- sim/edge_sensor_status_position_out_tb.sv
// Purpose: Self-checking bench for the status and position formatter
// Assumes: One measurement per strobe, answer one cycle later
// Notes:   Expected words are queued by the driver, popped on update
`timescale 1ns/1ps
`include "edge_sensor_params.svh"

module edge_sensor_status_position_out_tb;
  logic        clk_i, rst_n_i, meas_valid_i, no_sensor_i, low_contrast_i, no_web_i;
  logic        wrong_orient_i, flutter_i, type_second_i, place_left_i, place_right_i;
  logic        mode_contrast_i, contrast_seen_i, win_open_i, win_covered_i, update_o;
  logic [3:0]  pix_code_i;
  logic [15:0] left_edge_raw_i, right_edge_raw_i, contrast_pos_i;
  logic [15:0] status_word_o, left_edge_o, right_pos_o, lfsr, pos_w, cen_w;
  logic [47:0] exp_q[$], last, e;
  logic        pos_ok, plc_due, ok_l;
  logic [16:0] sum_l;
  int          n_mismatch, n_checks;

  edge_sensor_status_position_out dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .meas_valid_i(meas_valid_i), .no_sensor_i(no_sensor_i), .low_contrast_i(low_contrast_i),
    .no_web_i(no_web_i), .wrong_orient_i(wrong_orient_i), .flutter_i(flutter_i),
    .type_second_i(type_second_i), .place_left_i(place_left_i), .place_right_i(place_right_i),
    .pix_code_i(pix_code_i), .mode_contrast_i(mode_contrast_i),
    .left_edge_raw_i(left_edge_raw_i), .right_edge_raw_i(right_edge_raw_i),
    .contrast_pos_i(contrast_pos_i), .contrast_seen_i(contrast_seen_i),
    .win_open_i(win_open_i), .win_covered_i(win_covered_i), .status_word_o(status_word_o),
    .left_edge_o(left_edge_o), .right_pos_o(right_pos_o), .update_o(update_o));
  plc_reader plc_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .update_i(update_o),
    .status_i(status_word_o), .left_i(left_edge_o), .right_i(right_pos_o),
    .pos_ok_o(pos_ok), .width_o(pos_w), .centre_o(cen_w));

  // ==========================================================
  // Helpers
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [15:0] pix_of(input logic t, input logic [3:0] c);
    case ({t, c})
      5'h00:   return `PIX_A0;
      5'h01:   return `PIX_A1;
      5'h02:   return `PIX_A2;
      5'h03:   return `PIX_A3;
      5'h05:   return `PIX_A5;
      5'h06:   return `PIX_A6;
      5'h07:   return `PIX_A7;
      5'h08:   return `PIX_A8;
      5'h11:   return `PIX_B1;
      5'h12:   return `PIX_B2;
      5'h13:   return `PIX_B3;
      5'h14:   return `PIX_B4;
      5'h15:   return `PIX_B5;
      5'h18:   return `PIX_B8;
      5'h1C:   return `PIX_B12;
      default: return `PIX_NONE;
    endcase
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      n_mismatch++;
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Random flags and positions, fixed code and type
  task automatic drive(input logic t, input logic [3:0] c);
    logic [15:0] px, lw, rw;
    logic        l_only, r_only;
    lfsr = next_rand(next_rand(next_rand(lfsr)));
    {no_sensor_i, low_contrast_i, no_web_i, wrong_orient_i, flutter_i, place_left_i,
     place_right_i, mode_contrast_i, contrast_seen_i, win_open_i, win_covered_i} = lfsr[10:0];
    lfsr = next_rand(lfsr);
    left_edge_raw_i = lfsr;
    right_edge_raw_i = ~lfsr;
    contrast_pos_i = {lfsr[7:0], lfsr[15:8]};
    type_second_i = t;
    pix_code_i = c;
    meas_valid_i = 1'b1;
    px = pix_of(t, c);
    l_only = place_left_i & ~place_right_i;
    r_only = place_right_i & ~place_left_i;
    lw = (mode_contrast_i | r_only) ? 16'h0000 :
         (l_only & win_open_i) ? px : (l_only & win_covered_i) ? 16'h0000 :
         left_edge_raw_i;
    rw = mode_contrast_i ? (contrast_seen_i ? contrast_pos_i : px) :
         (r_only & win_open_i) ? 16'h0000 : (r_only & win_covered_i) ? px :
         right_edge_raw_i;
    exp_q.push_back({mode_contrast_i, 1'b0, c, place_right_i, place_left_i, t, 1'b0,
                     flutter_i, 1'b0, wrong_orient_i, no_web_i, low_contrast_i,
                     no_sensor_i, lw, rw});
    @(posedge clk_i);
    #1;
  endtask

  // ==========================================================
  // Clock, monitor and watchdog
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // Reader captures on the update edge, so its outputs lag the words by one cycle
  always @(negedge clk_i)
  begin
    if (plc_due === 1'b1)
    begin
      ok_l = (last[47:46] == 2'b00) && !(last[41] && !last[40]);
      sum_l = {1'b0, last[31:16]} + {1'b0, last[15:0]};
      check("plc ok", {15'h0000, pos_ok}, {15'h0000, ~(last[32] | last[34])});
      check("plc width", pos_w, ok_l ? last[15:0] - last[31:16] : 16'h0000);
      check("plc centre", cen_w, ok_l ? sum_l[16:1] : last[15:0]);
    end
    plc_due = (update_o === 1'b1);
    if (update_o === 1'b1)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 48'hxxxx_xxxx_xxxx;
      last = e;
      check("status", status_word_o, e[47:32]);
      check("left", left_edge_o, e[31:16]);
      check("right", right_pos_o, e[15:0]);
    end
  end

  initial
  begin
    #(8 * 2000);
    n_mismatch++;
    print_verdict();
  end

  // ==========================================================
  // Tests
  initial
  begin
    {meas_valid_i, no_sensor_i, low_contrast_i, no_web_i, wrong_orient_i, flutter_i,
     type_second_i, place_left_i, place_right_i, mode_contrast_i, contrast_seen_i,
     win_open_i, win_covered_i} = 13'h0000;
    {pix_code_i, left_edge_raw_i, right_edge_raw_i, contrast_pos_i} = 52'h0;
    lfsr = 16'h93DC;
    rst_n_i = 1'b0;
    repeat (10) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    @(posedge clk_i);
    #1;
    check("reset status", status_word_o, 16'h0000);
    check("reset left", left_edge_o, 16'h0000);
    check("reset right", right_pos_o, 16'h0000);
    check("reset update", {15'h0000, update_o}, 16'h0000);
    $display("test reset values done");
    for (int i = 0; i < 32; i++)
      drive(i[4], i[3:0]);
    $display("test pixel code table done");
    for (int i = 0; i < 200; i++)
      drive(lfsr[13], lfsr[12:9]);
    $display("test random measurements done");
    meas_valid_i = 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
    check("update idle", {15'h0000, update_o}, 16'h0000);
    check("pending", 16'(exp_q.size()), 16'h0000);
    check("held status", status_word_o, last[47:32]);
    check("held left", left_edge_o, last[31:16]);
    check("held right", right_pos_o, last[15:0]);
    $display("test hold without strobe done");
    print_verdict();
  end
endmodule

//--- sim/plc_reader.sv
// Purpose: Far-side consumer of the published sensor words
// Assumes: Words are read on each update pulse
// Notes:   Derives validity, width and centreline as a remote reader would
`timescale 1ns/1ps

module plc_reader
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Published words
  input  wire logic        update_i,
  input  wire logic [15:0] status_i,
  input  wire logic [15:0] left_i,
  input  wire logic [15:0] right_i,
  // Derived values
  output logic             pos_ok_o,
  output logic      [15:0] width_o,
  output logic      [15:0] centre_o
);
  // ==========================================================
  // Decode
  wire         edge_mode  = (status_i[15:14] == 2'b00);
  wire         right_only = status_i[9] & ~status_i[8];
  wire         left_ok    = edge_mode & ~right_only;
  wire  [16:0] edge_sum   = {1'b0, left_i} + {1'b0, right_i};

  // ==========================================================
  // Capture
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pos_ok_o <= 1'b0;
      width_o  <= 16'h0000;
      centre_o <= 16'h0000;
    end
    else if (update_i)
    begin
      pos_ok_o <= ~(status_i[0] | status_i[2]);
      width_o  <= left_ok ? right_i - left_i : 16'h0000;
      centre_o <= left_ok ? edge_sum[16:1] : right_i;
    end
  end
endmodule
